// file: prsi_core.v
// run/stop control with run and error LED drivers and a small register port
//
// Summary of operation
// - The program runs only with the switch at run and a cold, warm or hot start taken.
// - Switch and start command may arrive in either order; running starts once both hold.
// - A pending start with the switch at stop quick-flashes both LEDs at 1:8.
// - The green LED is off while stopped for any reason, except with a start pending or in reset mode.
// - The green LED slow-flashes 1:1 while running.
// - In reset mode both LEDs quick-flash 1:1.
// - The red LED is off with no error in normal state.
// - A start with an invalid configuration stops and lights red steadily.
// - A severe runtime fault stops running and lights red steadily.
// - A host network error slow-flashes red 1:1 and running continues.
// - The network error clears itself on the next good host exchange.
// - The cause of a severe fault is kept for report at next power-on.
`timescale 1ns/100ps
`default_nettype none
`include "prsi_regs.vh"
module prsi_core #(
  parameter DIV_W = `PRSI_DIV_W,
  parameter [DIV_W-1:0] BLINK_DIV = `PRSI_DIV_RST
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire run_switch_i,
  input wire fault_i,
  input wire [`PRSI_FAULT_W-1:0] fault_code_i,
  input wire [`PRSI_FAULT_W-1:0] fault_kept_i,
  input wire [`PRSI_ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  output wire [`PRSI_FAULT_W-1:0] fault_store_o,
  output wire fault_store_we_o,
  output wire prog_run_o,
  output reg led_green_o,
  output reg led_red_o,
  output wire irq_o
);
  // ----------------------------------------------------------------
  // state codes
  // ----------------------------------------------------------------
  localparam [1:0] ST_STOP = 2'h0;
  localparam [1:0] ST_PEND = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;
  localparam [1:0] ST_RST = 2'h3;
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg sw_m_q, sw_q, flt_m_q, flt_q, flt_d1_q;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_m_q <= 1'b0;
      sw_q <= 1'b0;
      flt_m_q <= 1'b0;
      flt_q <= 1'b0;
      flt_d1_q <= 1'b0;
    end else begin
      sw_m_q <= run_switch_i;
      sw_q <= sw_m_q;
      flt_m_q <= fault_i;
      flt_q <= flt_m_q;
      flt_d1_q <= flt_q;
    end
  end
  wire fault_rise;
  assign fault_rise = flt_q & ~flt_d1_q;
  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  wire wr_ctrl, wr_istat, wr_imask, wr_div;
  assign wr_ctrl = wr_i && (addr_i == `PRSI_OFF_CTRL);
  assign wr_istat = wr_i && (addr_i == `PRSI_OFF_IRQ_STAT);
  assign wr_imask = wr_i && (addr_i == `PRSI_OFF_IRQ_MASK);
  assign wr_div = wr_i && (addr_i == `PRSI_OFF_DIV);
  wire cmd_start, cmd_stop, cmd_rst, cmd_net_err, cmd_net_ok, cmd_cfg_bad;
  assign cmd_start = wr_ctrl && (wdata_i[`PRSI_CTRL_COLD] || wdata_i[`PRSI_CTRL_WARM] ||
                                 wdata_i[`PRSI_CTRL_HOT]);
  assign cmd_stop = wr_ctrl && wdata_i[`PRSI_CTRL_STOP];
  assign cmd_rst = wr_ctrl && wdata_i[`PRSI_CTRL_RESET_MODE];
  assign cmd_net_err = wr_ctrl && wdata_i[`PRSI_CTRL_NET_ERR];
  assign cmd_net_ok = wr_ctrl && wdata_i[`PRSI_CTRL_NET_OK];
  assign cmd_cfg_bad = wdata_i[`PRSI_CTRL_CFG_BAD];
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg prog_valid_q, cfg_bad_q;
  reg [DIV_W-1:0] div_q;
  reg [`PRSI_IRQ_W-1:0] imask_q;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_valid_q <= 1'b0;
      cfg_bad_q <= 1'b0;
      div_q <= `PRSI_DIV_RST;
      imask_q <= `PRSI_IRQ_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        prog_valid_q <= wdata_i[`PRSI_CTRL_PROG_VALID];
        cfg_bad_q <= cmd_cfg_bad;
      end
      if (wr_div)
        div_q <= wdata_i[DIV_W-1:0];
      if (wr_imask)
        imask_q <= wdata_i[`PRSI_IRQ_W-1:0];
    end
  end
  // ----------------------------------------------------------------
  // run state machine
  // ----------------------------------------------------------------
  reg [1:0] state_q, state_d;
  reg err_q, err_d, net_q, net_d;
  reg [`PRSI_FAULT_W-1:0] fault_q, fault_d;
  reg fault_we;
  wire cfg_ok;
  assign cfg_ok = prog_valid_q & ~cfg_bad_q;
  always @* begin
    state_d = state_q;
    err_d = err_q;
    net_d = net_q;
    fault_d = fault_q;
    fault_we = 1'b0;
    if (cmd_net_err)
      net_d = 1'b1;
    else if (cmd_net_ok)
      net_d = 1'b0;
    case (state_q)
      ST_STOP: begin
        if (cmd_rst)
          state_d = ST_RST;
        else if (cmd_start)
          state_d = ST_PEND;
      end
      ST_PEND: begin
        if (cmd_stop)
          state_d = ST_STOP;
        else if (cmd_rst)
          state_d = ST_RST;
        else if (sw_q) begin
          if (cfg_ok) begin
            state_d = ST_RUN;
            err_d = 1'b0;
          end else begin
            state_d = ST_STOP;
            err_d = 1'b1;
            fault_d = `PRSI_FAULT_CFG;
            fault_we = 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (fault_rise) begin
          state_d = ST_STOP;
          err_d = 1'b1;
          fault_d = fault_code_i;
          fault_we = 1'b1;
        end else if (cmd_stop || !sw_q)
          state_d = ST_STOP;
        else if (cmd_rst)
          state_d = ST_RST;
      end
      ST_RST: begin
        if (cmd_stop)
          state_d = ST_STOP;
        else if (cmd_start)
          state_d = ST_PEND;
      end
      default: state_d = ST_STOP;
    endcase
    if (cmd_start && state_q != ST_RUN)
      err_d = 1'b0;
  end
  // fault cause reloaded from non-volatile store after power-on
  reg load_q;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_STOP;
      err_q <= 1'b0;
      net_q <= 1'b0;
      fault_q <= `PRSI_FAULT_RST;
      load_q <= 1'b1;
    end else begin
      state_q <= state_d;
      err_q <= err_d;
      net_q <= net_d;
      load_q <= 1'b0;
      fault_q <= load_q ? fault_kept_i : fault_d;
    end
  end
  assign fault_store_o = fault_q;
  assign fault_store_we_o = fault_we;
  assign prog_run_o = (state_q == ST_RUN);
  // ----------------------------------------------------------------
  // blink base and LED patterns
  // ----------------------------------------------------------------
  wire q11, q18, s11;
  prsi_blink #(
    .DIV_W(DIV_W)
  ) u_blink (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .period_i(div_q),
    .quick_11_o(q11),
    .quick_18_o(q18),
    .slow_11_o(s11)
  );
  reg led_g_d, led_r_d;
  always @* begin
    led_g_d = 1'b0;
    led_r_d = 1'b0;
    case (state_q)
      ST_PEND: begin
        led_g_d = q18;
        led_r_d = q18;
      end
      ST_RUN: led_g_d = s11;
      ST_RST: begin
        led_g_d = q11;
        led_r_d = q11;
      end
      default: led_g_d = 1'b0;
    endcase
    // steady error outranks the flash patterns of the red LED, but reset mode owns both LEDs
    if (err_q && state_q != ST_RST)
      led_r_d = 1'b1;
    else if (net_q && state_q != ST_RST && state_q != ST_PEND)
      led_r_d = s11;
  end
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_green_o <= 1'b0;
      led_red_o <= 1'b0;
    end else begin
      led_green_o <= led_g_d;
      led_red_o <= led_r_d;
    end
  end
  // ----------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  wire [`PRSI_IRQ_W-1:0] ev;
  assign ev[`PRSI_IRQ_START] = (state_d == ST_RUN) && (state_q != ST_RUN);
  assign ev[`PRSI_IRQ_STOP] = (state_d == ST_STOP) && (state_q == ST_RUN);
  assign ev[`PRSI_IRQ_FAULT] = fault_we;
  assign ev[`PRSI_IRQ_NET] = net_d & ~net_q;
  reg [`PRSI_IRQ_W-1:0] istat_q;
  genvar gi;
  generate
    for (gi = 0; gi < `PRSI_IRQ_W; gi = gi + 1) begin : g_irq
      always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
          istat_q[gi] <= 1'b0;
        else if (ev[gi])
          istat_q[gi] <= 1'b1;
        else if (wr_istat && wdata_i[gi])
          istat_q[gi] <= 1'b0;
      end
    end
  endgenerate
  assign irq_o = |(istat_q & imask_q);
  // ----------------------------------------------------------------
  // read port: data one cycle after strobe, unmapped reads zero
  // ----------------------------------------------------------------
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    case (addr_i)
      `PRSI_OFF_CTRL: begin
        rd_d[`PRSI_CTRL_PROG_VALID] = prog_valid_q;
        rd_d[`PRSI_CTRL_CFG_BAD] = cfg_bad_q;
      end
      `PRSI_OFF_STAT: begin
        rd_d[`PRSI_STAT_RUN] = (state_q == ST_RUN);
        rd_d[`PRSI_STAT_PEND] = (state_q == ST_PEND);
        rd_d[`PRSI_STAT_ERR] = err_q;
        rd_d[`PRSI_STAT_NET] = net_q;
        rd_d[`PRSI_STAT_RESET] = (state_q == ST_RST);
        rd_d[`PRSI_STAT_SWITCH] = sw_q;
        rd_d[`PRSI_STAT_LED_G] = led_green_o;
        rd_d[`PRSI_STAT_LED_R] = led_red_o;
      end
      `PRSI_OFF_IRQ_STAT: rd_d[`PRSI_IRQ_W-1:0] = istat_q;
      `PRSI_OFF_IRQ_MASK: rd_d[`PRSI_IRQ_W-1:0] = imask_q;
      `PRSI_OFF_FAULT: rd_d[`PRSI_FAULT_W-1:0] = fault_q;
      `PRSI_OFF_DIV: rd_d[DIV_W-1:0] = div_q;
      default: rd_d = 32'h00000000;
    endcase
  end
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)
      rdata_o <= 32'h00000000;
    else if (rd_i)
      rdata_o <= rd_d;
    else
      rdata_o <= 32'h00000000;
  end
endmodule // prsi_core
`default_nettype wire

// file: prsi_regs.vh
// register offsets, field positions, reset values and timing counts of the run/stop indicator
`ifndef PRSI_REGS_VH
`define PRSI_REGS_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PRSI_ADDR_W 4
`define PRSI_OFF_CTRL 4'h0
`define PRSI_OFF_STAT 4'h1
`define PRSI_OFF_IRQ_STAT 4'h2
`define PRSI_OFF_IRQ_MASK 4'h3
`define PRSI_OFF_FAULT 4'h4
`define PRSI_OFF_DIV 4'h5
// ----------------------------------------------------------------
// control register fields (bits 0-6: write one = command pulse; bits 7-8 are stored on every write)
// ----------------------------------------------------------------
`define PRSI_CTRL_COLD 0
`define PRSI_CTRL_WARM 1
`define PRSI_CTRL_HOT 2
`define PRSI_CTRL_STOP 3
`define PRSI_CTRL_RESET_MODE 4
`define PRSI_CTRL_NET_ERR 5
`define PRSI_CTRL_NET_OK 6
`define PRSI_CTRL_PROG_VALID 7
`define PRSI_CTRL_CFG_BAD 8
// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define PRSI_STAT_RUN 0
`define PRSI_STAT_PEND 1
`define PRSI_STAT_ERR 2
`define PRSI_STAT_NET 3
`define PRSI_STAT_RESET 4
`define PRSI_STAT_SWITCH 5
`define PRSI_STAT_LED_G 6
`define PRSI_STAT_LED_R 7
// ----------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------
`define PRSI_IRQ_W 4
`define PRSI_IRQ_START 0
`define PRSI_IRQ_STOP 1
`define PRSI_IRQ_FAULT 2
`define PRSI_IRQ_NET 3
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define PRSI_FAULT_W 4
`define PRSI_FAULT_RST 4'h0
`define PRSI_FAULT_CFG 4'hF
`define PRSI_IRQ_MASK_RST 4'h0
`define PRSI_DIV_W 24
`define PRSI_BLINK_NS 50000000
`define PRSI_CLK_NS 20
`define PRSI_DIV_RST 24'h2625A0
`define PRSI_QUICK_SHIFT 2
`endif

// file: prsi_blink.v
// blink pulse base: shared divider producing quick and slow patterns
`timescale 1ns/100ps
`default_nettype none
`include "prsi_regs.vh"
module prsi_blink #(
  parameter DIV_W = `PRSI_DIV_W
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire [DIV_W-1:0] period_i,
  output reg quick_11_o,
  output reg quick_18_o,
  output reg slow_11_o
);
  // ----------------------------------------------------------------
  // base tick
  // ----------------------------------------------------------------
  reg [DIV_W-1:0] cnt_q;
  reg [2:0] phase_q;
  wire tick;
  assign tick = (cnt_q >= period_i);
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= {DIV_W{1'b0}};
      phase_q <= 3'h0;
    end else if (tick) begin
      cnt_q <= {DIV_W{1'b0}};
      phase_q <= phase_q + 3'h1;
    end else begin
      cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end
  // ----------------------------------------------------------------
  // patterns: quick 1:1 is 4x slow, quick 1:8 shares the slow period, all from one phase counter
  // ----------------------------------------------------------------
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quick_11_o <= 1'b0;
      quick_18_o <= 1'b0;
      slow_11_o <= 1'b0;
    end else begin
      quick_11_o <= phase_q[0];
      quick_18_o <= (phase_q[2:0] == 3'h7);
      slow_11_o <= phase_q[`PRSI_QUICK_SHIFT];
    end
  end
endmodule // prsi_blink
`default_nettype wire

// file: prsi_core_monitor.sv
// assertion checker on the ports of the run/stop indicator
`timescale 1ns/100ps
`default_nettype none
`include "prsi_regs.vh"
module prsi_core_monitor (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic run_switch_i,
  input wire logic fault_i,
  input wire logic [`PRSI_FAULT_W-1:0] fault_code_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [`PRSI_FAULT_W-1:0] fault_store_o,
  input wire logic fault_store_we_o,
  input wire logic prog_run_o,
  input wire logic led_green_o,
  input wire logic led_red_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // sized for the bench divider; the reset divider never runs the program
  localparam int HOLD_MAX = 40;
  logic [7:0] hold_q;
  logic green_q;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_q <= 8'h00;
      green_q <= 1'b0;
    end else begin
      green_q <= led_green_o;
      if (!prog_run_o || led_green_o != green_q) hold_q <= 8'h00;
      else if (hold_q != 8'hFF) hold_q <= hold_q + 8'h01;
    end
  end
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its slot");
  a_green_stop: assert property (
    led_green_o && !$past(prog_run_o) |-> led_red_o) else $error("green lit while stopped");
  a_run_green: assert property (hold_q <= HOLD_MAX)
    else $error("green not flashing while running");
  a_run_switch: assert property ($rose(prog_run_o) |-> $past(run_switch_i, 2))
    else $error("run without switch");
  a_switch_stop: assert property (
    prog_run_o && !run_switch_i |-> ##[1:4] !prog_run_o) else $error("switch stop missed");
  a_fault_stop: assert property (
    prog_run_o && $rose(fault_i) |-> ##[1:6] !prog_run_o ##1 !prog_run_o [*8])
    else $error("fault did not stop");
  a_fault_red: assert property (
    prog_run_o && $rose(fault_i) |-> ##[3:8] led_red_o [*8]) else $error("red not steady");
  a_fault_kept: assert property (
    prog_run_o && $rose(fault_i) |-> ##[1:6] fault_store_we_o ##[0:1]
    fault_store_o == fault_code_i) else $error("fault cause not kept");
endmodule // prsi_core_monitor
bind prsi_core prsi_core_monitor u_mon (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .run_switch_i(run_switch_i), .fault_i(fault_i), .fault_code_i(fault_code_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .fault_store_o(fault_store_o), .fault_store_we_o(fault_store_we_o),
  .prog_run_o(prog_run_o), .led_green_o(led_green_o), .led_red_o(led_red_o));
`default_nettype wire

// file: prsi_panel_model.sv
// panel model: run/stop switch, fault source and kept fault cause
`timescale 1ns/100ps
`default_nettype none
module prsi_panel_model #(
  parameter logic [3:0] KEPT = 4'h5 // arbitrary kept cause
) (
  input wire logic clock_i,
  input wire logic want_run_i,
  input wire logic want_fault_i,
  input wire logic [3:0] code_i,
  output var logic run_switch_o = 1'b0,
  output var logic fault_o = 1'b0,
  output var logic [3:0] fault_code_o = 4'h0,
  output logic [3:0] fault_kept_o
);
  always_ff @(posedge clock_i) begin
    run_switch_o <= want_run_i;
    fault_o <= want_fault_i;
    fault_code_o <= code_i;
  end
  assign fault_kept_o = KEPT;
endmodule // prsi_panel_model
`default_nettype wire

// file: prsi_core_tb.sv
// self-checking bench of the run/stop indicator
`timescale 1ns/100ps
`default_nettype none
module prsi_core_tb;
  localparam logic [3:0] KEPT = 4'hA;
  localparam int TICK = 4; // divider written as 3
  localparam int WIN = 16 * TICK;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic want_run = 1'b0;
  logic want_fault = 1'b0;
  logic [3:0] code = 4'h1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic run_sw, flt, we, prun, led_g, led_r, irq;
  logic [3:0] fcode, kept, store;
  logic [31:0] rdata;
  int errors = 0;
  int total_checks = 0;
  always #10 clock_i = ~clock_i;
  prsi_panel_model #(.KEPT(KEPT)) panel (.clock_i(clock_i), .want_run_i(want_run),
    .want_fault_i(want_fault), .code_i(code), .run_switch_o(run_sw), .fault_o(flt),
    .fault_code_o(fcode), .fault_kept_o(kept));
  prsi_core uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .run_switch_i(run_sw), .fault_i(flt),
    .fault_code_i(fcode), .fault_kept_i(kept), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .fault_store_o(store), .fault_store_we_o(we),
    .prog_run_o(prun), .led_green_o(led_g), .led_red_o(led_r), .irq_o(irq));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  // program-valid rides on every command write
  task automatic ctrl(input logic [31:0] b);
    wr_reg(4'h0, b | 32'h80);
  endtask
  task automatic wait_run(input logic e);
    for (int n = 0; n < 40 && prun !== e; n++) @(posedge clock_i);
    chk({31'h0, prun}, {31'h0, e});
  endtask
  task automatic leds(input int g, input int r);
    int cg;
    int cr;
    cg = 0;
    cr = 0;
    repeat (8) @(posedge clock_i);
    repeat (WIN) begin
      @(posedge clock_i);
      cg += int'(led_g === 1'b1);
      cr += int'(led_r === 1'b1);
    end
    chk(g, g == cg ? g : cg);
    chk(32'(cg), 32'(g));
    chk(32'(cr), 32'(r));
  endtask
  // lit cycles in a window: 1 steady, 2 slow 1:1, 3 quick 1:1, 4 standby 1:8
  function automatic int on_cnt(input int kind);
    case (kind)
      1: return WIN;
      2: return WIN * (4 * TICK) / (8 * TICK);
      3: return WIN * TICK / (2 * TICK);
      4: return WIN * TICK / (8 * TICK);
      default: return 0;
    endcase
  endfunction
  task final_report;
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(20 * 30000);
    errors++;
    final_report();
  end
  initial begin
    void'($urandom(25));
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd_chk(4'h4, 32'hF, {28'h0, KEPT});
    rd_chk(4'h5, 32'hFFFFFF, 32'h2625A0);
    rd_chk(4'hF, 32'hFFFFFFFF, 32'h0);
    wr_reg(4'h5, 32'h3);
    wr_reg(4'h3, 32'hF);
    for (int i = 0; i < 3; i++) begin
      // first pass always command-first, then random order
      if (i == 0 || $urandom_range(1, 0) == 1) begin
        ctrl(32'h1 << i);
        leds(on_cnt(4), on_cnt(4));
        want_run <= 1'b1;
      end else begin
        want_run <= 1'b1;
        leds(0, 0);
        ctrl(32'h1 << i);
      end
      wait_run(1'b1);
      chk({31'h0, irq}, 32'h1);
      wr_reg(4'h2, 32'hF);
      #1 chk({31'h0, irq}, 32'h0);
      leds(on_cnt(2), 0);
      want_run <= 1'b0;
      wait_run(1'b0);
      leds(0, 0);
    end
    want_run <= 1'b1;
    ctrl(32'h1);
    wait_run(1'b1);
    ctrl(32'h20);
    leds(on_cnt(2), on_cnt(2));
    chk({31'h0, prun}, 32'h1);
    ctrl(32'h40);
    leds(on_cnt(2), 0);
    ctrl(32'h8);
    wait_run(1'b0);
    leds(0, 0);
    code <= 4'($urandom_range(14, 1));
    ctrl(32'h4);
    wait_run(1'b1);
    want_fault <= 1'b1;
    wait_run(1'b0);
    want_fault <= 1'b0;
    leds(0, on_cnt(1));
    rd_chk(4'h4, 32'hF, {28'h0, code});
    chk({28'h0, store}, {28'h0, code});
    ctrl(32'h101);
    leds(0, on_cnt(1));
    chk({31'h0, prun}, 32'h0);
    rd_chk(4'h4, 32'hF, 32'hF);
    ctrl(32'h10);
    leds(on_cnt(3), on_cnt(3));
    ctrl(32'h8);
    final_report();
  end
endmodule // prsi_core_tb
`default_nettype wire
